// [artfr_pkg.sv]
// ------------------------------------------------------------
// artfr package: register map, reset values, timing tables
// ------------------------------------------------------------
package artfr_pkg;

   // ----------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------
   localparam logic [7:0] IDX_START_STOP_PERIOD = 8'h1a;
   localparam logic [7:0] IDX_OSCILLATOR_TRIM = 8'h1b;
   localparam logic [7:0] IDX_FAULT_RECOVERY_PERIOD = 8'h1c;
   localparam logic [7:0] IDX_INPUT_ROUTING = 8'h20;
   localparam logic [7:0] IDX_CONTROL = 8'h30;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h31;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h32;
   localparam logic [7:0] IDX_CLOCK_RATE = 8'h33;

   // ----------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------
   localparam logic [7:0] RST_START_STOP_PERIOD = 8'h0f;
   localparam logic [3:0] RST_FAULT_RECOVERY = 4'h2;
   localparam logic [7:0] RST_ROUTING_MODE = 8'h01;   // bits 23:16
   localparam logic [7:0] RST_ROUTING_HIGH = 8'h00;   // bits 31:24
   localparam logic [7:0] RST_ROUTING_B1 = 8'h77;     // bits 15:8
   localparam logic [7:0] RST_ROUTING_B0 = 8'h72;     // bits 7:0
   localparam logic RST_SHUTDOWN = 1'b1;
   localparam int RAMP_DIS_BIT = 7;
   localparam int TRIM_DONE_BIT = 6;
   localparam int TRIM_SEL_BIT = 1;
   localparam int CTRL_SD_BIT = 0;
   localparam int CH1_MODE_BIT = 7;                 // bit 23 of routing word
   localparam int CH2_MODE_BIT = 3;                 // bit 19 of routing word
   localparam logic [2:0] SRC_LEFT = 3'h0;
   localparam logic [2:0] SRC_RIGHT = 3'h1;
   localparam logic [2:0] SRC_ZERO = 3'h6;
   // interrupt status bits
   localparam int EV_RAMP_DONE = 0;
   localparam int EV_TRIM_DONE = 1;
   localparam int EV_FAULT = 2;
   localparam int EV_RESTART = 3;

   // ----------------------------------------------------------
   // timing: clock rate and derived scale factors
   // ----------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int CYC_PER_TENTH_MS = CLK_HZ / 10_000;
   localparam int CYC_PER_MS = CLK_HZ / 1_000;
   localparam int TRIM_CYCLES = 2000;

   typedef enum logic [1:0] {
      FLT_IDLE = 2'b00,
      FLT_WAIT = 2'b01,
      FLT_RESTART = 2'b10
   } artfr_flt_state_type;

   // ramp period in tenths of a millisecond for codes 01000..11111
   function automatic logic [31:0] artfr_ramp_tenths(input logic [4:0] code);
      case (code)
         5'h08: artfr_ramp_tenths = 32'd165;
         5'h09: artfr_ramp_tenths = 32'd239;
         5'h0a: artfr_ramp_tenths = 32'd314;
         5'h0b: artfr_ramp_tenths = 32'd404;
         5'h0c: artfr_ramp_tenths = 32'd539;
         5'h0d: artfr_ramp_tenths = 32'd703;
         5'h0e: artfr_ramp_tenths = 32'd942;
         5'h0f: artfr_ramp_tenths = 32'd1257;
         5'h10: artfr_ramp_tenths = 32'd1646;
         5'h11: artfr_ramp_tenths = 32'd2394;
         5'h12: artfr_ramp_tenths = 32'd3142;
         5'h13: artfr_ramp_tenths = 32'd4039;
         5'h14: artfr_ramp_tenths = 32'd5386;
         5'h15: artfr_ramp_tenths = 32'd7031;
         5'h16: artfr_ramp_tenths = 32'd9425;
         5'h17: artfr_ramp_tenths = 32'd12566;
         5'h18: artfr_ramp_tenths = 32'd17281;
         5'h19: artfr_ramp_tenths = 32'd25136;
         5'h1a: artfr_ramp_tenths = 32'd32991;
         5'h1b: artfr_ramp_tenths = 32'd42417;
         5'h1c: artfr_ramp_tenths = 32'd56556;
         5'h1d: artfr_ramp_tenths = 32'd73837;
         5'h1e: artfr_ramp_tenths = 32'd98973;
         5'h1f: artfr_ramp_tenths = 32'd131964;
         default: artfr_ramp_tenths = 32'd0;
      endcase
   endfunction

   // fault recovery wait in milliseconds
   function automatic logic [31:0] artfr_fault_ms(input logic [3:0] code);
      case (code)
         4'h3: artfr_fault_ms = 32'd449;
         4'h4: artfr_fault_ms = 32'd598;
         4'h5: artfr_fault_ms = 32'd748;
         4'h6: artfr_fault_ms = 32'd898;
         4'h7: artfr_fault_ms = 32'd1047;
         4'h8: artfr_fault_ms = 32'd1197;
         4'h9: artfr_fault_ms = 32'd1346;
         4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: artfr_fault_ms = 32'd1496;
         default: artfr_fault_ms = 32'd299;
      endcase
   endfunction

endpackage

// [artfr_top.sv]
// Contract
// - ramp timer runs on shutdown or pin change
// - period bits 4:3 zero means no ramp
// - five-bit code selects ramp interval from table
// - rate of serial frames measured by own clock
// - writing zero to trim selects factory trim
// - trim done flag reads 0 until done
// - trim select bit resets to one
// - power stage fault resets stage, halts output
// - wait programmed period, then restart power stage
// - four-bit code selects recovery wait from table
// - recovery register accepts one write per reset
// - bits 23 and 19 select three-level modulation
// - bits 22:20 select channel 1 source
// - bits 18:16 select channel 2 source
`timescale 1ns/1ns
module artfr_top
   import artfr_pkg::*;
#(
   parameter int SAMPLE_W = 24,
   parameter int RAMP_TENTH_CYC = CYC_PER_TENTH_MS,
   parameter int FAULT_MS_CYC = CYC_PER_MS,
   parameter int TRIM_CYC = TRIM_CYCLES
) (
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [9:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   input wire logic I_POWER_DOWN_PIN,
   input wire logic I_POWER_STAGE_FAULT,
   input wire logic I_SERIAL_BCLK,
   input wire logic I_SERIAL_LRCLK,
   input wire logic I_SERIAL_DATA,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   output logic O_IRQ,
   output logic O_SHUTDOWN,
   output logic O_RAMP_ACTIVE,
   output logic O_TRIM_DONE,
   output logic O_FACTORY_TRIM,
   output logic O_POWER_STAGE_RESET,
   output logic O_PWM_HALT,
   output logic O_POWER_STAGE_RESTART,
   output logic [SAMPLE_W-1:0] O_CH1_DATA,
   output logic [SAMPLE_W-1:0] O_CH2_DATA,
   output logic O_CH1_THREE_LEVEL,
   output logic O_CH2_THREE_LEVEL,
   output logic O_SAMPLE_VALID
);

   // ----------------------------------------------------------
   // state of the whole block
   // ----------------------------------------------------------
   typedef struct packed {
      logic s1_pdn, s2_pdn, pdn_prev;          // power-down pin sync
      logic s1_flt, s2_flt, flt_prev;          // fault input sync
      logic s1_sck, s2_sck, sck_prev;          // bit clock sync
      logic s1_lr, s2_lr, lr_prev, lr_d;       // frame clock sync
      logic s1_din, s2_din;                    // serial data sync
      logic [SAMPLE_W-1:0] shreg;              // incoming bits
      logic [SAMPLE_W-1:0] left;               // last left slot
      logic [SAMPLE_W-1:0] ch1;                // routed channel 1
      logic [SAMPLE_W-1:0] ch2;                // routed channel 2
      logic valid;                             // new sample pulse
      logic [7:0] ramp_ctl;                    // start/stop period reg
      logic ramp_busy;
      logic [31:0] ramp_cnt;
      logic ctrl_sd, sd_prev;                  // all-channel shutdown
      logic factory_sel;                       // inverse of trim bit 1
      logic trim_done, trim_busy;
      logic [15:0] trim_cnt;
      logic [3:0] flt_code;                    // recovery period code
      logic flt_locked;                        // one write taken
      artfr_flt_state_type fstate;
      logic [31:0] flt_cnt;
      logic pstage_reset, pwm_halt, restart;
      logic [7:0] route;                       // routing bits 23:16
      logic [15:0] rate_cnt, rate;             // frame period in clocks
      logic [3:0] irq_stat, irq_mask;
      logic irq;
      logic ack;
      logic [31:0] rdat;
   } artfr_state_type;

   artfr_state_type r, n;
   logic rst_meta, rst_n;                      // released reset copy

   // ----------------------------------------------------------
   // reset release through two flip-flops
   // ----------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // picks the source of one channel from its three-bit code
   function automatic logic [SAMPLE_W-1:0] route_src(input logic [2:0] code,
         input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] rt);
      case (code)
         SRC_LEFT: route_src = l;
         SRC_RIGHT: route_src = rt;
         default: route_src = '0;   // ground and reserved codes give silence
      endcase
   endfunction

   // ----------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------
   logic req, wr;
   logic [7:0] idx;
   logic ramp_trig, sck_rise, lr_rise;
   logic [SAMPLE_W-1:0] right_w;
   logic [3:0] ev;

   always_comb begin
      n = r;
      ev = 4'h0;
      right_w = '0;
      idx = I_WB_ADR[9:2];
      req = I_WB_CYC && I_WB_STB && !r.ack;
      // write lands on the edge where the master sees ack high
      wr = I_WB_CYC && I_WB_STB && I_WB_WE && r.ack;
      // input synchronisers: second stage only reads the first
      n.s1_pdn = I_POWER_DOWN_PIN;
      n.s2_pdn = r.s1_pdn;
      n.s1_flt = I_POWER_STAGE_FAULT;
      n.s2_flt = r.s1_flt;
      n.s1_sck = I_SERIAL_BCLK;
      n.s2_sck = r.s1_sck;
      n.s1_lr = I_SERIAL_LRCLK;
      n.s2_lr = r.s1_lr;
      n.s1_din = I_SERIAL_DATA;
      n.s2_din = r.s1_din;
      n.pdn_prev = r.s2_pdn;
      n.sd_prev = r.ctrl_sd;
      n.flt_prev = r.s2_flt;
      n.sck_prev = r.s2_sck;
      n.lr_d = r.s2_lr;
      n.valid = 1'b0;
      n.restart = 1'b0;

      // single-cycle bus answer; read data registered with ack
      n.ack = req;
      n.rdat = 32'h0;
      if (wr) begin
         case (idx)
            IDX_START_STOP_PERIOD: if (I_WB_SEL[0]) n.ramp_ctl = I_WB_DAT[7:0];
            IDX_OSCILLATOR_TRIM: begin
               if (I_WB_SEL[0]) begin
                  n.factory_sel = !I_WB_DAT[TRIM_SEL_BIT];
                  n.trim_done = 1'b0;
                  n.trim_busy = 1'b1;
                  n.trim_cnt = 16'(TRIM_CYC - 1);
               end
            end
            IDX_FAULT_RECOVERY_PERIOD: begin
               // later writes are dropped silently until reset
               if (I_WB_SEL[0] && !r.flt_locked) begin
                  n.flt_code = I_WB_DAT[3:0];
                  n.flt_locked = 1'b1;
               end
            end
            IDX_INPUT_ROUTING: if (I_WB_SEL[2]) n.route = I_WB_DAT[23:16];
            IDX_CONTROL: if (I_WB_SEL[0]) n.ctrl_sd = I_WB_DAT[CTRL_SD_BIT];
            IDX_IRQ_MASK: if (I_WB_SEL[0]) n.irq_mask = I_WB_DAT[3:0];
            default: ;   // unmapped and read-only: acked, no effect
         endcase
      end else if (req && !I_WB_WE) begin
         case (idx)
            IDX_START_STOP_PERIOD: n.rdat = {24'h0, r.ramp_ctl};
            IDX_OSCILLATOR_TRIM: begin
               n.rdat = 32'h0;
               n.rdat[TRIM_DONE_BIT] = r.trim_done;
               n.rdat[TRIM_SEL_BIT] = !r.factory_sel;
            end
            IDX_FAULT_RECOVERY_PERIOD: n.rdat = {28'h0, r.flt_code};
            IDX_INPUT_ROUTING: n.rdat = {RST_ROUTING_HIGH, r.route,
               RST_ROUTING_B1, RST_ROUTING_B0};
            IDX_CONTROL: n.rdat = {31'h0, r.ctrl_sd};
            IDX_IRQ_STATUS: n.rdat = {28'h0, r.irq_stat};
            IDX_IRQ_MASK: n.rdat = {28'h0, r.irq_mask};
            IDX_CLOCK_RATE: n.rdat = {16'h0, r.rate};
            default: n.rdat = 32'h0;
         endcase
      end

      // soft start/stop timer on shutdown or pin change
      ramp_trig = (r.s2_pdn != r.pdn_prev) || (r.ctrl_sd != r.sd_prev);
      if (ramp_trig) begin
         // disabled or code 00xxx: no half-duty interval at all
         if (!r.ramp_ctl[RAMP_DIS_BIT] && (r.ramp_ctl[4:3] != 2'b00)) begin
            n.ramp_busy = 1'b1;
            n.ramp_cnt = 32'(artfr_ramp_tenths(r.ramp_ctl[4:0])
               * RAMP_TENTH_CYC) - 32'd1;
         end else begin
            n.ramp_busy = 1'b0;
         end
      end else if (r.ramp_busy) begin
         if (r.ramp_cnt == 32'd0) begin
            n.ramp_busy = 1'b0;
            ev[EV_RAMP_DONE] = 1'b1;
         end else begin
            n.ramp_cnt = r.ramp_cnt - 32'd1;
         end
      end

      // oscillator trim sequence
      if (r.trim_busy && !wr) begin
         if (r.trim_cnt == 16'd0) begin
            n.trim_busy = 1'b0;
            n.trim_done = 1'b1;
            ev[EV_TRIM_DONE] = 1'b1;
         end else begin
            n.trim_cnt = r.trim_cnt - 16'd1;
         end
      end

      // power stage fault recovery
      case (r.fstate)
         FLT_IDLE: begin
            if (r.s2_flt && !r.flt_prev) begin
               n.fstate = FLT_WAIT;
               n.pstage_reset = 1'b1;
               n.pwm_halt = 1'b1;
               n.flt_cnt = 32'(artfr_fault_ms(r.flt_code) * FAULT_MS_CYC) - 32'd1;
               ev[EV_FAULT] = 1'b1;
            end
         end
         FLT_WAIT: begin
            if (r.flt_cnt == 32'd0) begin
               n.fstate = FLT_RESTART;
               n.pstage_reset = 1'b0;
               n.restart = 1'b1;
               ev[EV_RESTART] = 1'b1;
            end else begin
               n.flt_cnt = r.flt_cnt - 32'd1;
            end
         end
         FLT_RESTART: begin
            n.fstate = FLT_IDLE;
            n.pwm_halt = 1'b0;
         end
         default: n.fstate = FLT_IDLE;
      endcase

      // frame rate measured only once the oscillator is trimmed
      lr_rise = r.s2_lr && !r.lr_d;
      if (!r.trim_done) begin
         n.rate_cnt = 16'h0;
         n.rate = 16'h0;
      end else if (lr_rise) begin
         n.rate = r.rate_cnt;
         n.rate_cnt = 16'h1;
      end else if (r.rate_cnt != 16'hffff) begin
         n.rate_cnt = r.rate_cnt + 16'h1;
      end

      // serial receive: words end where the frame clock flips
      sck_rise = r.s2_sck && !r.sck_prev;
      if (sck_rise) begin
         n.shreg = {r.shreg[SAMPLE_W-2:0], r.s2_din};
         n.lr_prev = r.s2_lr;
         if (r.s2_lr != r.lr_prev) begin
            if (!r.lr_prev) begin
               n.left = r.shreg;
            end else begin
               right_w = r.shreg;
               n.ch1 = route_src(r.route[6:4], r.left, right_w);
               n.ch2 = route_src(r.route[2:0], r.left, right_w);
               n.valid = 1'b1;
            end
         end
      end

      // sticky events: a set in the clearing cycle wins
      if (wr && idx == IDX_IRQ_STATUS && I_WB_SEL[0]) begin
         n.irq_stat = r.irq_stat & ~I_WB_DAT[3:0];
      end
      n.irq_stat = n.irq_stat | ev;
      n.irq = |(n.irq_stat & n.irq_mask);
   end

   // ----------------------------------------------------------
   // state register
   // ----------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.ramp_ctl <= RST_START_STOP_PERIOD;
         r.ctrl_sd <= RST_SHUTDOWN;
         r.sd_prev <= RST_SHUTDOWN;
         r.flt_code <= RST_FAULT_RECOVERY;
         r.route <= RST_ROUTING_MODE;
         r.fstate <= FLT_IDLE;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------
   // outputs, each straight from the state register
   // ----------------------------------------------------------
   assign O_WB_DAT = r.rdat;
   assign O_WB_ACK = r.ack;
   assign O_IRQ = r.irq;
   assign O_SHUTDOWN = r.ctrl_sd;
   assign O_RAMP_ACTIVE = r.ramp_busy;
   assign O_TRIM_DONE = r.trim_done;
   assign O_FACTORY_TRIM = r.factory_sel;
   assign O_POWER_STAGE_RESET = r.pstage_reset;
   assign O_PWM_HALT = r.pwm_halt;
   assign O_POWER_STAGE_RESTART = r.restart;
   assign O_CH1_DATA = r.ch1;
   assign O_CH2_DATA = r.ch2;
   assign O_CH1_THREE_LEVEL = r.route[CH1_MODE_BIT];
   assign O_CH2_THREE_LEVEL = r.route[CH2_MODE_BIT];
   assign O_SAMPLE_VALID = r.valid;

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!rst_n);

   logic flt_wr_seen;
   assign flt_wr_seen = wr && idx == IDX_FAULT_RECOVERY_PERIOD && I_WB_SEL[0];

   sequence s_fault_enter;
      r.fstate == FLT_IDLE && r.s2_flt && !r.flt_prev;
   endsequence

   sequence s_trim_start;
      wr && idx == IDX_OSCILLATOR_TRIM && I_WB_SEL[0];
   endsequence

   a_ack_single_pulse: assert property (r.ack |=> !r.ack)
      else $error("bus ack held longer than one cycle");
   a_ramp_starts: assert property (ramp_trig && !r.ramp_ctl[7]
      && r.ramp_ctl[4:3] != 2'b00 |=> r.ramp_busy)
      else $error("ramp did not start on trigger");
   a_ramp_none_zero: assert property (ramp_trig && r.ramp_ctl[4:3] == 2'b00
      |=> !r.ramp_busy)
      else $error("ramp ran although period code is zero");
   a_ramp_load: assert property (ramp_trig && !r.ramp_ctl[7]
      && r.ramp_ctl[4:0] == 5'h08 |=> r.ramp_cnt == 32'(165 * RAMP_TENTH_CYC - 1))
      else $error("ramp count wrong for shortest code");
   a_trim_clear: assert property (s_trim_start |=> !r.trim_done && r.trim_busy
      && r.trim_cnt == 16'(TRIM_CYC - 1))
      else $error("trim done flag not cleared on start");
   a_trim_finish: assert property (r.trim_busy && r.trim_cnt == 16'h0 && !wr
      |=> r.trim_done)
      else $error("trim done flag not set at end of count");
   a_factory_sel: assert property ((s_trim_start and I_WB_DAT[7:0] == 8'h00)
      |=> r.factory_sel)
      else $error("zero write did not select factory trim");
   a_fault_halt: assert property (s_fault_enter |=> r.pwm_halt && r.pstage_reset
      ##1 r.pwm_halt[*8])
      else $error("fault did not halt output");
   a_fault_restart: assert property (r.restart |-> $past(r.fstate) == FLT_WAIT
      ##1 !r.pwm_halt && r.fstate == FLT_IDLE)
      else $error("restart out of sequence");
   a_fault_once: assert property (r.flt_locked && flt_wr_seen |=> $stable(r.flt_code))
      else $error("recovery code changed after first write");
   a_route_zero: assert property (r.valid && r.route[6:4] == SRC_ZERO
      |-> r.ch1 == '0)
      else $error("channel 1 not silent for ground code");
   a_irq_level: assert property (O_IRQ == |(r.irq_stat & r.irq_mask))
      else $error("interrupt level disagrees with status");

endmodule // artfr_top

// [artfr_audio_src.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// serial audio source: two slots a frame, link clock only in frames
// ------------------------------------------------------------
module artfr_audio_src #(
   parameter int W = 24
) (
   output logic o_bclk,
   output logic o_lrclk,
   output logic o_data
);
   // idle: link clock parked low, slot select low
   initial begin
      o_bclk = 1'b0;
      o_lrclk = 1'b0;
      o_data = 1'b0;
   end

   // one frame, msb first; select rises with the msb of the right slot,
   // one extra tick with select low closes the right slot
   task automatic send(input logic [W-1:0] l, input logic [W-1:0] r);
      logic [2*W:0] w;
      w = {l, r, 1'b0};
      for (int i = 0; i <= 2*W; i++) begin
         o_data = w[2*W-i];
         o_lrclk = (i >= W) && (i < 2*W);
         #62 o_bclk = 1'b1;
         #63 o_bclk = 1'b0;
      end
      // released line: inverse, so a stale bit never looks valid
      o_data = ~o_data;
   endtask
endmodule // artfr_audio_src

// [testbench.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------
// bench: registers, trim, ramp, routing, fault recovery
// ------------------------------------------------------------
module testbench import artfr_pkg::*;;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
   logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic power_down_pin = 1'b0, flt = 1'b0, sd = 1'b1;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, dat;
   logic bclk, lrclk, sdat, ack, irq, shut, ramp, tdone, ftrim, psrst, halt, rstart, v, m1, m2;
   logic [23:0] ch1, ch2, c1, c2;
   logic [7:0] pval[4] = '{8'h0f, 8'h08, 8'h8f, 8'h07};
   logic [7:0] rmode[5] = '{8'h01, 8'h10, 8'he6, 8'h89, 8'h72};
   logic [3:0] fcode[3] = '{4'h2, 4'h9, 4'hb};
   int plen[4] = '{1257, 165, 0, 0};
   int fwait[3] = '{299, 1346, 1496};
   int n_mismatch = 0, total_checks = 0, cycles = 0, n;

   artfr_top #(.RAMP_TENTH_CYC(1), .FAULT_MS_CYC(1), .TRIM_CYC(20)) dut (
      .I_CLK_SYS(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .I_POWER_DOWN_PIN(power_down_pin),
      .I_POWER_STAGE_FAULT(flt), .I_SERIAL_BCLK(bclk), .I_SERIAL_LRCLK(lrclk),
      .I_SERIAL_DATA(sdat), .O_WB_DAT(dat), .O_WB_ACK(ack), .O_IRQ(irq),
      .O_SHUTDOWN(shut), .O_RAMP_ACTIVE(ramp), .O_TRIM_DONE(tdone),
      .O_FACTORY_TRIM(ftrim), .O_POWER_STAGE_RESET(psrst), .O_PWM_HALT(halt),
      .O_POWER_STAGE_RESTART(rstart), .O_CH1_DATA(ch1), .O_CH2_DATA(ch2),
      .O_CH1_THREE_LEVEL(m1), .O_CH2_THREE_LEVEL(m2), .O_SAMPLE_VALID(v));
   artfr_audio_src #(.W(24)) src (.o_bclk(bclk), .o_lrclk(lrclk), .o_data(sdat));

   // 100 mhz system clock
   always #5 clk = ~clk;

   // hang guard: whole run needs well under this
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // keep the last routed pair; valid is a one-cycle pulse
   always @(posedge clk) begin
      if (v === 1'b1) begin
         c1 <= ch1;
         c2 <= ch2;
      end
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // reset held 12 cycles, then wait for the internal release
   task automatic do_reset();
      nrst <= 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   // classic cycle: hold until ack is sampled, then drop for a cycle
   task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'hf;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) begin
         @(posedge clk);
         t++;
      end
      `CHK(t, 1)
      rdat = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
      wb(1'b0, idx, 32'h0);
      `CHK(rdat, e)
   endtask

   // length of a high interval that must start within a few cycles
   task automatic meas(ref logic sig, output int len);
      int w;
      w = 0;
      len = 0;
      while (sig !== 1'b1 && w < 10) begin
         @(posedge clk);
         w++;
      end
      while (sig === 1'b1 && len < 20000) begin
         @(posedge clk);
         len++;
      end
   endtask

   // expected sample per source code; reserved codes give silence
   function automatic logic [23:0] exp_src(input logic [2:0] c, input logic [23:0] l,
                                           input logic [23:0] r);
      exp_src = (c == 3'h0) ? l : (c == 3'h1) ? r : 24'h0;
   endfunction

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      do_reset();
      rd_chk(IDX_START_STOP_PERIOD, 32'h0000000f);
      rd_chk(IDX_OSCILLATOR_TRIM, 32'h00000002);
      rd_chk(IDX_FAULT_RECOVERY_PERIOD, 32'h00000002);
      rd_chk(IDX_INPUT_ROUTING, 32'h00017772);
      rd_chk(8'h3f, 32'h0);
      wb(1'b1, IDX_OSCILLATOR_TRIM, 32'h0);
      rd_chk(IDX_OSCILLATOR_TRIM, 32'h0);
      repeat (30) @(posedge clk);
      rd_chk(IDX_OSCILLATOR_TRIM, 32'h40);
      `CHK({tdone, ftrim}, 2'b11)
      // trim event: sticky, masked, then cleared by writing one
      rd_chk(IDX_IRQ_STATUS, 32'h2);
      `CHK(irq, 1'b0)
      wb(1'b1, IDX_IRQ_MASK, 32'h2);
      @(posedge clk);
      `CHK(irq, 1'b1)
      wb(1'b1, IDX_IRQ_STATUS, 32'h2);
      @(posedge clk);
      `CHK(irq, 1'b0)
      // ramps: shutdown and pin triggers alternate; disabled and 00xxx give none
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, IDX_START_STOP_PERIOD, {24'h0, pval[i]});
         if (i % 2 == 1) begin
            power_down_pin <= ~power_down_pin;
         end else begin
            sd = ~sd;
            wb(1'b1, IDX_CONTROL, {31'h0, sd});
         end
         meas(ramp, n);
         `CHK(n >= plen[i] - 3 && n <= plen[i] + 3, 1'b1)
      end
      // two frames back to back: 49 ticks of 125 ns, about 612 cycles
      src.send(24'h123456, 24'habcdef);
      src.send(24'h123456, 24'habcdef);
      wb(1'b0, IDX_CLOCK_RATE, 32'h0);
      `CHK(rdat >= 611 && rdat <= 614, 1'b1)
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, IDX_INPUT_ROUTING, {8'h00, rmode[i], 16'h7772});
         src.send(24'h5a0000 + 24'(i), 24'ha5c300 + 24'(i));
         repeat (8) @(posedge clk);
         `CHK(c1, exp_src(rmode[i][6:4], 24'h5a0000 + 24'(i), 24'ha5c300 + 24'(i)))
         `CHK(c2, exp_src(rmode[i][2:0], 24'h5a0000 + 24'(i), 24'ha5c300 + 24'(i)))
         `CHK({m1, m2}, {rmode[i][7], rmode[i][3]})
         `CHK(shut, 1'b1)
      end
      // fault recovery: one write per reset, then wait by code
      for (int i = 0; i < 3; i++) begin
         do_reset();
         wb(1'b1, IDX_FAULT_RECOVERY_PERIOD, {28'h0, fcode[i]});
         wb(1'b1, IDX_FAULT_RECOVERY_PERIOD, 32'h5);
         rd_chk(IDX_FAULT_RECOVERY_PERIOD, {28'h0, fcode[i]});
         flt <= 1'b1;
         meas(psrst, n);
         `CHK(n >= fwait[i] - 3 && n <= fwait[i] + 3, 1'b1)
         `CHK({halt, rstart}, 2'b11)
         @(posedge clk);
         `CHK(halt, 1'b0)
         flt <= 1'b0;
      end
      finish_test();
   end
endmodule // testbench
